// *** src/console_key_control.sv ***
// Console key and switch control for the processor and memory subroutine
`timescale 1ns/1ps
module console_key_control #(
  parameter int unsigned TIMEOUT_CYC = console_pkg::TIMEOUT_CYC,
  parameter int unsigned REPEAT_MAX_CYC = console_pkg::REPEAT_MAX_CYC,
  parameter int unsigned PUNCH_IDLE_CYC = console_pkg::PUNCH_IDLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_key,
  input wire logic readin_key,
  input wire logic instruction_halt_key,
  input wire logic instruction_resume_key,
  input wire logic memory_halt_key,
  input wire logic memory_resume_key,
  input wire logic console_perform_key,
  input wire logic io_clear_key,
  input wire logic store_here_key,
  input wire logic store_following_key,
  input wire logic view_here_key,
  input wire logic view_following_key,
  input wire logic reader_on_key,
  input wire logic reader_off_key,
  input wire logic location_halt_sw,
  input wire logic timeout_hang_sw,
  input wire logic repeat_sw,
  input wire logic [2:0] speed_range,
  input wire logic [4:0] speed_fine,
  input wire logic lockout_sw,
  input wire logic [17:0] address_switches,
  input wire logic [35:0] data_switches,
  input wire logic inst_done,
  input wire logic fetch_pulse,
  input wire logic [17:0] fetch_addr,
  input wire logic mem_call,
  input wire logic [17:0] call_addr,
  input wire logic call_write,
  input wire logic call_rpw,
  input wire logic call_fetch,
  input wire logic [35:0] call_wdata,
  input wire logic mem_ack,
  input wire logic [35:0] mem_rdata,
  input wire logic punch_call,
  output logic run_flag,
  output logic readin_mode_flag,
  output logic seq_start,
  output logic [17:0] seq_start_addr,
  output logic seq_resume,
  output logic perform_go,
  output logic [35:0] perform_word,
  output logic pc_count_inhibit,
  output logic io_clear,
  output logic memory_stop_flag,
  output logic seq_restart,
  output logic [35:0] call_rdata,
  output logic mem_rd_req,
  output logic mem_wr_req,
  output logic [17:0] mem_addr,
  output logic [35:0] mem_wdata,
  output logic readin_area_sel,
  output logic [17:0] access_address_reg,
  output logic [35:0] memory_display,
  output logic missing_memory_flag,
  output logic proc_pi_req,
  output logic reader_motor,
  output logic reader_brake,
  output logic reader_pi_req,
  output logic punch_power
);
  logic [console_pkg::NUM_KEYS-1:0] key_raw;
  logic [console_pkg::NUM_KEYS-1:0] fire;
  logic [console_pkg::NUM_KEYS-1:0] tr;
  logic [31:0] repeat_interval;
  logic repeat_on;
  logic halt_held;
  logic mem_halt_on;
  logic loc_halt_on;
  logic hang_on;
  logic go_start;
  logic go_readin;
  logic go_resume;
  logic go_mem_resume;
  logic go_perform;
  logic go_io_clear;
  logic go_store_here;
  logic go_store_next;
  logic go_view_here;
  logic go_view_next;
  logic kp_valid;
  logic kp_write;
  logic [17:0] kp_addr;
  logic [35:0] kp_data;
  console_pkg::mem_state_type ms_state;
  logic split_pend;
  logic req_key;
  logic [31:0] tmo_cnt;
  logic [31:0] punch_cnt;
  logic start;
  logic [17:0] a_addr;
  logic a_wr;
  logic a_rpw;
  logic [35:0] a_data;
  logic split;
  logic stop_now;
  logic ack_done;
  logic tmo_hit;

  function automatic logic in_readin(input logic [17:0] addr);
    return addr <= console_pkg::READIN_TOP;
  endfunction

  // Six ranges, each sixteen times the last, fine knob spans 1..32
  function automatic logic [31:0] repeat_cycles(input logic [2:0] range,
                                                input logic [4:0] fine);
    logic [2:0] r;
    logic [63:0] v;
    r = (range > 3'(console_pkg::SPEED_RANGES - 1)) ?
        3'(console_pkg::SPEED_RANGES - 1) : range;
    v = (64'(console_pkg::REPEAT_MIN_CYC) * (64'(fine) + 64'h1))
        << (console_pkg::RANGE_SHIFT * r);
    if (v > 64'(REPEAT_MAX_CYC))
      v = 64'(REPEAT_MAX_CYC);
    return v[31:0];
  endfunction

  assign key_raw = {reader_off_key, reader_on_key, view_following_key,
                    view_here_key, store_following_key, store_here_key,
                    io_clear_key, console_perform_key, memory_resume_key,
                    instruction_resume_key, readin_key, start_key};

  generate
    for (genvar i = 0; i < console_pkg::NUM_KEYS; i++)
    begin : g_key
      key_trigger u_key (
        .clk(clk),
        .rst_n(rst_n),
        .key(key_raw[i]),
        .repeat_on(repeat_on),
        .interval(repeat_interval),
        .fire(fire[i])
      );
    end
  endgenerate

  // Reader keys stay live under lockout
  assign tr = fire & ~(lockout_sw ? console_pkg::LOCKABLE_KEYS : '0);
  assign repeat_on = repeat_sw & ~lockout_sw;
  assign halt_held = instruction_halt_key & ~lockout_sw;
  assign mem_halt_on = memory_halt_key & ~lockout_sw;
  assign loc_halt_on = location_halt_sw & ~lockout_sw;
  assign hang_on = timeout_hang_sw & ~lockout_sw;

  assign go_start = tr[console_pkg::K_START] & ~run_flag;
  assign go_readin = tr[console_pkg::K_READIN] & ~run_flag;
  assign go_resume = tr[console_pkg::K_INST_RESUME] & ~run_flag;
  assign go_perform = tr[console_pkg::K_PERFORM] & ~run_flag;
  assign go_io_clear = tr[console_pkg::K_IO_CLEAR] & ~run_flag;
  assign go_mem_resume = tr[console_pkg::K_MEM_RESUME] & memory_stop_flag;
  assign go_store_here = tr[console_pkg::K_STORE_HERE];
  assign go_store_next = tr[console_pkg::K_STORE_NEXT] & ~run_flag;
  assign go_view_here = tr[console_pkg::K_VIEW_HERE];
  assign go_view_next = tr[console_pkg::K_VIEW_NEXT] & ~run_flag;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      repeat_interval <= 32'(console_pkg::REPEAT_MIN_CYC);
    else
      repeat_interval <= repeat_cycles(speed_range, speed_fine);
  end

  // Resume wins over a held halt key, giving exactly one instruction
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run_flag <= 1'b0;
    else if (go_start || go_readin || go_resume)
      run_flag <= 1'b1;
    else if (halt_held)
      run_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seq_start <= 1'b0;
      seq_start_addr <= '0;
      seq_resume <= 1'b0;
      perform_go <= 1'b0;
      perform_word <= '0;
      io_clear <= 1'b0;
    end
    else
    begin
      seq_start <= go_start | go_readin;
      seq_resume <= go_resume;
      perform_go <= go_perform;
      io_clear <= go_io_clear;
      if (go_start || go_readin)
        seq_start_addr <= address_switches;
      if (go_perform)
        perform_word <= data_switches;
    end
  end

  // Held for the whole performed instruction: no count, jump saves as is
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pc_count_inhibit <= 1'b0;
    else if (go_perform)
      pc_count_inhibit <= 1'b1;
    else if (inst_done || go_io_clear)
      pc_count_inhibit <= 1'b0;
  end

  // Flag also disables fast memory while set
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      readin_mode_flag <= 1'b0;
    else if (go_readin)
      readin_mode_flag <= 1'b1;
    else if (go_io_clear)
      readin_mode_flag <= 1'b0;
    else if (fetch_pulse && !in_readin(fetch_addr))
      readin_mode_flag <= 1'b0;
  end

  // A second key op arriving while one waits is dropped, not queued
  always_ff @(posedge clk)
  begin
    if (!rst_n || go_io_clear)
      kp_valid <= 1'b0;
    else if (start && !mem_call)
      kp_valid <= 1'b0;
    else if (!kp_valid &&
             (go_store_here || go_store_next || go_view_here || go_view_next))
      kp_valid <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      kp_write <= 1'b0;
      kp_addr <= '0;
      kp_data <= '0;
    end
    else if (!kp_valid)
    begin
      kp_write <= go_store_here | go_store_next;
      kp_data <= data_switches;
      if (go_store_here || go_view_here)
        kp_addr <= address_switches;
      else
        kp_addr <= access_address_reg + console_pkg::ADDR_STEP;
    end
  end

  // Sequencer calls take priority over a waiting console op
  assign start = (ms_state == console_pkg::MS_IDLE) && (mem_call || kp_valid)
                 && !go_io_clear;
  assign a_addr = mem_call ? call_addr : kp_addr;
  assign a_wr = mem_call ? call_write : kp_write;
  assign a_rpw = mem_call & call_rpw;
  assign a_data = mem_call ? call_wdata : kp_data;
  assign split = a_rpw & call_fetch & (mem_halt_on | loc_halt_on);
  assign stop_now = mem_halt_on | (loc_halt_on & (a_addr == address_switches));
  assign ack_done = (ms_state == console_pkg::MS_BUSY) && mem_ack;
  assign tmo_hit = (ms_state == console_pkg::MS_BUSY) && !mem_ack &&
                   !hang_on && (tmo_cnt == TIMEOUT_CYC - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n || go_io_clear)
    begin
      ms_state <= console_pkg::MS_IDLE;
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      split_pend <= 1'b0;
      req_key <= 1'b0;
      tmo_cnt <= '0;
      seq_restart <= 1'b0;
      proc_pi_req <= 1'b0;
    end
    else
    begin
      seq_restart <= 1'b0;
      proc_pi_req <= 1'b0;
      unique case (ms_state)
        console_pkg::MS_IDLE:
          if (start)
          begin
            ms_state <= console_pkg::MS_BUSY;
            mem_rd_req <= ~a_wr | a_rpw;
            mem_wr_req <= a_wr & ~split;
            split_pend <= split;
            req_key <= ~mem_call;
            tmo_cnt <= '0;
          end
        console_pkg::MS_BUSY:
          if (ack_done || tmo_hit)
          begin
            mem_rd_req <= 1'b0;
            mem_wr_req <= 1'b0;
            proc_pi_req <= tmo_hit;
            if (ack_done && memory_stop_flag)
              ms_state <= console_pkg::MS_STOP;
            else if (ack_done && split_pend)
            begin
              // No stop at this address, so the held-back write follows now
              mem_wr_req <= 1'b1;
              split_pend <= 1'b0;
              tmo_cnt <= '0;
            end
            else
            begin
              ms_state <= console_pkg::MS_IDLE;
              split_pend <= 1'b0;
              seq_restart <= ~req_key;
            end
          end
          else
            tmo_cnt <= tmo_cnt + console_pkg::COUNT_STEP;
        console_pkg::MS_STOP:
          if (go_mem_resume && split_pend)
          begin
            ms_state <= console_pkg::MS_BUSY;
            mem_wr_req <= 1'b1;
            split_pend <= 1'b0;
            tmo_cnt <= '0;
          end
          else if (go_mem_resume)
          begin
            ms_state <= console_pkg::MS_IDLE;
            seq_restart <= ~req_key;
          end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      memory_stop_flag <= 1'b0;
    else if (start && stop_now)
      memory_stop_flag <= 1'b1;
    else if (go_mem_resume || go_io_clear)
      memory_stop_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      missing_memory_flag <= 1'b0;
    else if (tmo_hit)
      missing_memory_flag <= 1'b1;
    else if (go_io_clear)
      missing_memory_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_addr <= '0;
      mem_wdata <= '0;
      readin_area_sel <= 1'b0;
      access_address_reg <= '0;
    end
    else if (start)
    begin
      mem_addr <= a_addr;
      mem_wdata <= a_data;
      access_address_reg <= a_addr;
      readin_area_sel <= readin_mode_flag & in_readin(a_addr);
    end
  end

  // Display follows any access to the switch location, and every key op
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      memory_display <= '0;
      call_rdata <= '0;
    end
    else if (start && a_wr &&
             (!mem_call || a_addr == address_switches))
      memory_display <= a_data;
    else if (ack_done && mem_rd_req)
    begin
      if (req_key || mem_addr == address_switches)
        memory_display <= mem_rdata;
      if (!req_key)
        call_rdata <= mem_rdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reader_motor <= 1'b0;
      reader_brake <= 1'b0;
      reader_pi_req <= 1'b0;
    end
    else
    begin
      reader_pi_req <= tr[console_pkg::K_READER_ON] |
                       tr[console_pkg::K_READER_OFF];
      if (tr[console_pkg::K_READER_ON])
      begin
        reader_motor <= 1'b1;
        reader_brake <= 1'b1;
      end
      else if (tr[console_pkg::K_READER_OFF])
      begin
        reader_motor <= 1'b0;
        reader_brake <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      punch_power <= 1'b0;
      punch_cnt <= '0;
    end
    else if (punch_call)
    begin
      punch_power <= 1'b1;
      punch_cnt <= '0;
    end
    else if (punch_power)
    begin
      if (punch_cnt == PUNCH_IDLE_CYC - 1)
        punch_power <= 1'b0;
      punch_cnt <= punch_cnt + console_pkg::COUNT_STEP;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_split_read;
    start && split ##1 mem_rd_req && !mem_wr_req;
  endsequence

  sequence s_split_write;
    ms_state == console_pkg::MS_STOP && split_pend && go_mem_resume;
  endsequence

  a_start_run: assert property (go_start |=> run_flag && seq_start &&
    seq_start_addr == $past(address_switches))
    else $error("start did not set run at switch address");
  a_start_busy: assert property (run_flag |=> !seq_start)
    else $error("start acted while running");
  a_readin_steer: assert property (start && readin_mode_flag &&
    in_readin(a_addr) |=> readin_area_sel)
    else $error("readin access not steered");
  a_readin_leave: assert property (fetch_pulse &&
    !in_readin(fetch_addr) && !go_readin |=> !readin_mode_flag)
    else $error("readin flag kept after high fetch");
  a_halt_clear: assert property (halt_held && !go_start && !go_readin &&
    !go_resume |=> !run_flag)
    else $error("halt key left run set");
  a_memstop_set: assert property (start && mem_halt_on |=>
    memory_stop_flag)
    else $error("memory stop not set at subroutine start");
  a_split_cycle: assert property (s_split_read |->
    ##[1:1000] (s_split_write or !split_pend) ##1 1)
    else $error("split read not followed correctly");
  a_split_write: assert property (s_split_write |=>
    mem_wr_req && !mem_rd_req && ms_state == console_pkg::MS_BUSY)
    else $error("split write cycle not issued");
  a_resume_clear: assert property (go_mem_resume && !start |=>
    !memory_stop_flag)
    else $error("memory resume left stop flag set");
  a_perform_once: assert property (go_perform |=> perform_go &&
    pc_count_inhibit ##1 !perform_go)
    else $error("perform pulse or count inhibit wrong");
  a_timeout_flag: assert property (tmo_hit |=> missing_memory_flag &&
    proc_pi_req && !mem_rd_req && !mem_wr_req)
    else $error("timeout did not flag missing memory");
  a_lockout_keys: assert property (lockout_sw |=> !seq_start &&
    !seq_resume && !perform_go && !io_clear)
    else $error("locked key passed through");
  a_reader_on: assert property (tr[console_pkg::K_READER_ON] |=>
    reader_motor && reader_brake && reader_pi_req)
    else $error("reader on not applied");
  a_punch_on: assert property (punch_call |=> punch_power)
    else $error("punch not powered on call");
endmodule

// *** src/console_pkg.sv ***
// Constants and types for the console key control block
package console_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned NUM_KEYS = 12;
  localparam int unsigned K_START = 0;
  localparam int unsigned K_READIN = 1;
  localparam int unsigned K_INST_RESUME = 2;
  localparam int unsigned K_MEM_RESUME = 3;
  localparam int unsigned K_PERFORM = 4;
  localparam int unsigned K_IO_CLEAR = 5;
  localparam int unsigned K_STORE_HERE = 6;
  localparam int unsigned K_STORE_NEXT = 7;
  localparam int unsigned K_VIEW_HERE = 8;
  localparam int unsigned K_VIEW_NEXT = 9;
  localparam int unsigned K_READER_ON = 10;
  localparam int unsigned K_READER_OFF = 11;
  localparam logic [11:0] LOCKABLE_KEYS = 12'h3FF;
  localparam logic [17:0] READIN_TOP = 18'h0_000F;
  localparam logic [17:0] ADDR_STEP = 18'h0_0001;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned TIMEOUT_US = 100;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int unsigned REPEAT_MIN_NS = 3400;
  localparam int unsigned REPEAT_MIN_CYC =
    (REPEAT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REPEAT_MAX_S = 8;
  localparam int unsigned REPEAT_MAX_CYC = REPEAT_MAX_S * CLK_MHZ * 1000000;
  localparam int unsigned PUNCH_IDLE_S = 5;
  localparam int unsigned PUNCH_IDLE_CYC = PUNCH_IDLE_S * CLK_MHZ * 1000000;
  localparam int unsigned SPEED_RANGES = 6;
  localparam int unsigned RANGE_SHIFT = 4;
  typedef enum logic [1:0] {MS_IDLE, MS_BUSY, MS_STOP} mem_state_type;
endpackage

// *** src/key_trigger.sv ***
// Synchroniser, edge detector and repeat timer for one console key
`timescale 1ns/1ps
module key_trigger (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key,
  input wire logic repeat_on,
  input wire logic [31:0] interval,
  output logic fire
);
  logic sync1;
  logic sync2;
  logic held;
  logic [31:0] rep_cnt;
  logic rep_due;

  assign rep_due = rep_cnt == interval - console_pkg::COUNT_STEP;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      held <= 1'b0;
      fire <= 1'b0;
    end
    else
    begin
      sync1 <= key;
      sync2 <= sync1;
      held <= sync2;
      // One trigger per press; more only while repeat runs
      fire <= (sync2 & ~held) | (sync2 & held & repeat_on & rep_due);
    end
  end

  // Interval counter restarts on release so each hold times afresh
  always_ff @(posedge clk)
  begin
    if (!rst_n || !sync2 || !held || !repeat_on || rep_due)
      rep_cnt <= '0;
    else
      rep_cnt <= rep_cnt + console_pkg::COUNT_STEP;
  end
endmodule

// *** test/mem_model.sv ***
// Memory model that answers the block's memory requests
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic wr,
  input wire logic [17:0] addr,
  input wire logic silent,
  output logic ack,
  output logic [35:0] rdata
);
  logic [1:0] wait_cnt;
  initial
  begin
    ack = 1'b0;
    rdata = 36'h0_0000_0000;
    wait_cnt = 2'h0;
  end
  // Data toggles outside answers so a stale capture cannot match
  always @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if ((rd || wr) && !silent && !ack)
    begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h1)
      begin
        ack <= 1'b1;
        rdata <= {18'h0_0000, addr};
        wait_cnt <= 2'h0;
      end
    end
  end
endmodule

// *** test/tb_console_key_control.sv ***
// Self-checking bench for the console key control block
`timescale 1ns/1ps
module tb_console_key_control;
  logic clk = 0, rst_n = 0, silent = 0, rd_free = 0;
  logic [11:0] k = 0;
  logic instruction_halt_key = 0, memory_halt_key = 0;
  logic lockout_sw = 0, inst_done = 0, fetch_pulse = 0;
  logic mem_call = 0, punch_call = 0, mem_ack;
  logic location_halt_sw = 0, repeat_sw = 0, call_write = 0;
  logic call_rpw = 0, call_fetch = 0;
  logic [2:0] speed_range = 0;
  logic [4:0] speed_fine = 0;
  logic [17:0] address_switches = 0, fetch_addr = 0, call_addr = 0;
  logic [35:0] data_switches = 0, call_wdata = 0, mem_rdata;
  logic run_flag, readin_mode_flag, seq_start, seq_restart;
  logic memory_stop_flag, mem_rd_req, mem_wr_req, readin_area_sel;
  logic missing_memory_flag, reader_motor, punch_power;
  logic seq_resume, perform_go, pc_count_inhibit, io_clear, proc_pi_req;
  logic reader_brake, reader_pi_req;
  logic [17:0] seq_start_addr, mem_addr, a, b, access_address_reg;
  logic [35:0] call_rdata, perform_word, mem_wdata, memory_display, wd, w;
  logic [17:0] sq[$];
  logic [35:0] rq[$], pq[$];
  int fail_count = 0, checked = 0, cyc = 0, seed = 24123;
  int pulses = 0, pi_cnt = 0, wr_acks = 0;
  always #10 clk = ~clk;
  console_key_control #(.TIMEOUT_CYC(20), .PUNCH_IDLE_CYC(50),
    .REPEAT_MAX_CYC(5000)) i_dut (.clk, .rst_n, .start_key(k[0]),
    .readin_key(k[1]), .instruction_halt_key,
    .instruction_resume_key(k[2]), .memory_halt_key,
    .memory_resume_key(k[3]), .console_perform_key(k[4]),
    .io_clear_key(k[5]), .store_here_key(k[6]),
    .store_following_key(k[7]), .view_here_key(k[8]),
    .view_following_key(k[9]), .reader_on_key(k[10]),
    .reader_off_key(k[11]), .location_halt_sw,
    .timeout_hang_sw(1'b0), .repeat_sw, .speed_range,
    .speed_fine, .lockout_sw, .address_switches, .data_switches,
    .inst_done, .fetch_pulse, .fetch_addr, .mem_call, .call_addr,
    .call_write, .call_rpw, .call_fetch, .call_wdata,
    .mem_ack, .mem_rdata, .punch_call, .run_flag, .readin_mode_flag,
    .seq_start, .seq_start_addr, .seq_resume, .perform_go,
    .perform_word, .pc_count_inhibit, .io_clear, .memory_stop_flag,
    .seq_restart, .call_rdata, .mem_rd_req, .mem_wr_req, .mem_addr,
    .mem_wdata, .readin_area_sel, .access_address_reg,
    .memory_display, .missing_memory_flag, .proc_pi_req,
    .reader_motor, .reader_brake, .reader_pi_req, .punch_power);
  mem_model i_mem (.clk, .rd(mem_rd_req), .wr(mem_wr_req),
    .addr(mem_addr), .silent, .ack(mem_ack), .rdata(mem_rdata));
  task chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask
  task wrap_up;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Release well before the next press so the edge detector rearms
  task press(input int i);
    @(posedge clk) k[i] <= 1'b1;
    repeat (2) @(posedge clk);
    k[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task call(input logic [17:0] ad, input logic sel);
    @(posedge clk);
    mem_call <= 1'b1;
    call_addr <= ad;
    wd = $random(seed);
    call_wdata <= wd;
    @(posedge clk) mem_call <= 1'b0;
    #1 chk("rd_req", mem_rd_req, 1'b1);
    chk("wr_req", mem_wr_req, 1'b0);
    chk("wdata", mem_wdata, wd);
    chk("area_sel", readin_area_sel, sel);
    for (int j = 0; j < 40 && !seq_restart && !memory_stop_flag; j++)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // Watcher: each start pulse, and each restart pulse while rd_free is low, consumes the oldest note
  always @(posedge clk)
  begin
    #1;
    if (seq_start)
      chk("start_addr", seq_start_addr, sq.size() ? sq.pop_front() : '1);
    if (seq_restart && !rd_free)
      chk("call_rdata", call_rdata, rq.size() ? rq.pop_front() : '1);
    if (perform_go)
      chk("perform", perform_word,
          pq.size() ? pq.pop_front() : '1);
    pulses += int'(io_clear) + int'(seq_resume) + int'(proc_pi_req);
    pi_cnt += int'(reader_pi_req);
    wr_acks += int'(mem_ack && mem_wr_req && !mem_rd_req);
    if (++cyc == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    data_switches = $random(seed);
    speed_fine = $random(seed);
    speed_range = $random(seed);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    a = $random(seed);
    address_switches <= a;
    sq.push_back(a);
    press(0);
    chk("run", run_flag, 1'b1);
    press(0);
    instruction_halt_key <= 1'b1;
    repeat (6) @(posedge clk);
    press(2);
    chk("halt", run_flag, 1'b0);
    instruction_halt_key <= 1'b0;
    sq.push_back(a);
    press(1);
    chk("readin", readin_mode_flag, 1'b1);
    rq.push_back(36'h0_0000_0005);
    call(18'h0_0005, 1'b1);
    @(posedge clk);
    fetch_pulse <= 1'b1;
    fetch_addr <= 18'h0_0010;
    @(posedge clk) fetch_pulse <= 1'b0;
    repeat (3) @(posedge clk);
    chk("readin_clr", readin_mode_flag, 1'b0);
    instruction_halt_key <= 1'b1;
    memory_halt_key <= 1'b1;
    repeat (6) @(posedge clk);
    instruction_halt_key <= 1'b0;
    rq.push_back({18'h0_0000, a});
    call(a, 1'b0);
    chk("mem_stop", memory_stop_flag, 1'b1);
    memory_halt_key <= 1'b0;
    press(3);
    chk("resume", memory_stop_flag, 1'b0);
    silent <= 1'b1;
    rd_free <= 1'b1;
    call(18'h0_0100, 1'b0);
    chk("missing", missing_memory_flag, 1'b1);
    silent <= 1'b0;
    rd_free <= 1'b0;
    lockout_sw <= 1'b1;
    press(0);
    press(10);
    chk("motor_on", reader_motor, 1'b1);
    chk("brake_on", reader_brake, 1'b1);
    lockout_sw <= 1'b0;
    press(11);
    chk("motor_off", reader_motor, 1'b0);
    press(5);
    chk("io_clear", missing_memory_flag, 1'b0);
    chk("pulses", pulses, 3);
    w = $random(seed);
    data_switches <= w;
    pq.push_back(w);
    press(4);
    chk("inhibit", pc_count_inhibit, 1'b1);
    chk("perform_halt", run_flag, 1'b0);
    inst_done <= 1'b1;
    @(posedge clk) inst_done <= 1'b0;
    @(posedge clk);
    chk("inhibit_end", pc_count_inhibit, 1'b0);
    press(8);
    chk("view", memory_display, {18'h0_0000, a});
    chk("view_addr", access_address_reg, a);
    w = $random(seed);
    data_switches <= w;
    b = a + 18'h0_0001;
    press(7);
    chk("store", memory_display, w);
    chk("store_addr", access_address_reg, b);
    b = b + 18'h0_0001;
    press(9);
    chk("view_next", memory_display, {18'h0_0000, b});
    chk("view_next_addr", access_address_reg, b);
    location_halt_sw <= 1'b1;
    call_write <= 1'b1;
    call_rpw <= 1'b1;
    call_fetch <= 1'b1;
    rq.push_back({18'h0_0000, a});
    call(a, 1'b0);
    chk("loc_stop", memory_stop_flag, 1'b1);
    press(3);
    rq.push_back(36'h0_0000_0200);
    call(18'h0_0200, 1'b0);
    chk("writes", wr_acks, 3);
    location_halt_sw <= 1'b0;
    call_write <= 1'b0;
    call_rpw <= 1'b0;
    call_fetch <= 1'b0;
    speed_range <= 3'h0;
    speed_fine <= 5'h00;
    repeat_sw <= 1'b1;
    @(posedge clk) k[10] <= 1'b1;
    repeat (250) @(posedge clk);
    k[10] <= 1'b0;
    repeat (8) @(posedge clk);
    repeat_sw <= 1'b0;
    chk("reader_pi", pi_cnt, 4);
    @(posedge clk) punch_call <= 1'b1;
    @(posedge clk) punch_call <= 1'b0;
    repeat (2) @(posedge clk);
    chk("punch_on", punch_power, 1'b1);
    repeat (60) @(posedge clk);
    chk("punch_off", punch_power, 1'b0);
    chk("notes_left", 36'(sq.size() + rq.size() + pq.size()),
        36'h0_0000_0000);
    wrap_up();
  end
endmodule
